// ===== agcr_idle_timer.sv
// counts how long the converter has been enabled and idle
// assumes enable and idle are synchronous levels from the control register
`timescale 1ns/100ps
`default_nettype none
module agcr_idle_timer
   import agcr_pkg::*;
#(
   parameter int unsigned MIN_CYC = AGCR_IDLE_MIN_CYC
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic enabled_in,
   input wire logic idle_in,
   output logic open_out
);
   localparam int unsigned CNT_W = $clog2(MIN_CYC + 1);
   localparam logic [CNT_W-1:0] CNT_MAX = CNT_W'(MIN_CYC);

   logic [CNT_W-1:0] cnt_d;
   logic [CNT_W-1:0] cnt_q;

   // saturating count; any leave of idle restarts the wait
   always_comb begin
      cnt_d = cnt_q;
      if (rst_in || !enabled_in || !idle_in) begin
         cnt_d = '0;
      end else if (cnt_q != CNT_MAX) begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   always_ff @(posedge core_clk_in) begin
      cnt_q <= cnt_d;
   end

   assign open_out = (cnt_q == CNT_MAX);
endmodule : agcr_idle_timer
`default_nettype wire

// ===== agcr_pkg.sv
// package for the converter gain coefficient registers
// assumes a 32-bit APB slave at 50 MHz and byte addresses on paddr
package agcr_pkg;
   localparam int unsigned AGCR_ADDR_W = 32;
   localparam int unsigned AGCR_DATA_W = 32;
   localparam int unsigned AGCR_GAIN_W = 16;

   // register byte addresses
   localparam logic [31:0] AGCR_CUR_GAIN_ADDR = 32'hffff053c;
   localparam logic [31:0] AGCR_VOL_GAIN_ADDR = 32'hffff0540;
   localparam logic [31:0] AGCR_CTRL_ADDR = 32'hffff0600;
   localparam logic [31:0] AGCR_STATUS_ADDR = 32'hffff0604;

   // control register fields
   localparam int unsigned AGCR_CTRL_EN_BIT = 0;
   localparam int unsigned AGCR_CTRL_MODE_LSB = 1;
   localparam int unsigned AGCR_CTRL_MODE_W = 2;
   localparam logic [1:0] AGCR_MODE_IDLE = 2'h0;
   localparam logic [1:0] AGCR_MODE_CONVERT = 2'h1;
   localparam logic [1:0] AGCR_MODE_CAL_CUR = 2'h2;
   localparam logic [1:0] AGCR_MODE_CAL_VOL = 2'h3;
   localparam logic [2:0] AGCR_CTRL_RESET = 3'h0;

   // status register fields
   localparam int unsigned AGCR_STAT_OPEN_BIT = 0;
   localparam int unsigned AGCR_STAT_BUSY_BIT = 1;
   localparam int unsigned AGCR_STAT_REFUSED_BIT = 2;

   // scaling: coefficient of 0x8000 means unity gain
   localparam int unsigned AGCR_GAIN_FRAC = 15;

   // least enabled-and-idle time before coefficient writes are accepted
   localparam int unsigned AGCR_CLK_PERIOD_PS = 20000;
   localparam int unsigned AGCR_IDLE_MIN_PS = 23000000;
   localparam int unsigned AGCR_IDLE_MIN_CYC =
      (AGCR_IDLE_MIN_PS + AGCR_CLK_PERIOD_PS - 1) / AGCR_CLK_PERIOD_PS;
endpackage : agcr_pkg

// ===== agcr_props.sv
// checker for the gain coefficient block, watching top-level ports only
// assumes binding to agcr_top, one clock domain, synchronous reset
`timescale 1ns/100ps
`default_nettype none
module agcr_props
   import agcr_pkg::*;
#(
   parameter int unsigned RES_W = 16
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [AGCR_ADDR_W-1:0] paddr_in,
   input wire logic [AGCR_DATA_W-1:0] pwdata_in,
   input wire logic pready_out,
   input wire logic conv_enable_out,
   input wire logic [AGCR_CTRL_MODE_W-1:0] conv_mode_out,
   input wire logic cal_start_out,
   input wire logic cal_done_in,
   input wire logic [RES_W-1:0] cur_raw_in,
   input wire logic cur_raw_valid_in,
   input wire logic vol_raw_valid_in,
   input wire logic [RES_W-1:0] cur_result_out,
   input wire logic cur_result_valid_out,
   input wire logic vol_result_valid_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   logic wr_acc;
   logic ctrl_wr;
   assign wr_acc = psel_in && penable_in && pwrite_in;
   assign ctrl_wr = wr_acc && (paddr_in == AGCR_CTRL_ADDR);
   a_cur_valid_next: assert property (cur_raw_valid_in |=> cur_result_valid_out)
      else $error("current result valid missing");
   a_vol_valid_next: assert property (vol_raw_valid_in |=> vol_result_valid_out)
      else $error("voltage result valid missing");
   a_cur_zero_scale: assert property (cur_raw_valid_in && cur_raw_in == '0
      |=> cur_result_out == '0) else $error("zero raw not scaled to zero");
   a_start_one_pulse: assert property (cal_start_out |=> !cal_start_out)
      else $error("calibration start longer than one cycle");
   a_start_has_cause: assert property (cal_start_out |->
      $past(ctrl_wr && pwdata_in[0] && pwdata_in[2])) else $error("start without cal write");
   a_ctrl_write_mode: assert property (ctrl_wr && !cal_done_in |=>
      conv_mode_out == $past(pwdata_in[2:1]) && conv_enable_out == $past(pwdata_in[0]))
      else $error("control write not applied");
   a_done_ends_cal: assert property (cal_done_in && conv_enable_out && conv_mode_out[1]
      && !wr_acc |=> conv_mode_out == AGCR_MODE_IDLE) else $error("mode kept after done");
   a_ready_no_wait: assert property (psel_in && penable_in |-> pready_out)
      else $error("access phase without ready");
endmodule : agcr_props
`default_nettype wire

// ===== agcr_scaler.sv
// scales one channel's raw conversion result by its gain coefficient
// assumes unsigned results; product saturates at full scale
`timescale 1ns/100ps
`default_nettype none
module agcr_scaler
   import agcr_pkg::*;
#(
   parameter int unsigned RES_W = 16
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   input wire logic [RES_W-1:0] raw_in,
   input wire logic raw_valid_in,
   input wire logic [AGCR_GAIN_W-1:0] gain_in,
   output logic [RES_W-1:0] scaled_out,
   output logic scaled_valid_out
);
   localparam int unsigned PROD_W = RES_W + AGCR_GAIN_W;

   logic [PROD_W-1:0] prod;
   logic [RES_W-1:0] scaled_d;
   logic [RES_W-1:0] scaled_q;
   logic valid_d;
   logic valid_q;

   always_comb begin
      prod = PROD_W'(raw_in) * PROD_W'(gain_in);
      scaled_d = scaled_q;
      valid_d = 1'b0;
      if (rst_in) begin
         scaled_d = '0;
      end else if (raw_valid_in) begin
         valid_d = 1'b1;
         // gains above unity may overflow; clip rather than wrap
         if (prod[PROD_W-1]) begin
            scaled_d = '1;
         end else begin
            scaled_d = prod[AGCR_GAIN_FRAC +: RES_W];
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      scaled_q <= scaled_d;
      valid_q <= valid_d;
   end

   assign scaled_out = scaled_q;
   assign scaled_valid_out = valid_q;
endmodule : agcr_scaler
`default_nettype wire

// ===== agcr_top.sv
// gain coefficient registers of the current and voltage converters, APB slave
// assumes converter core answers a calibration start with one done pulse
//
// Summary of operation
// - hold a 16-bit current gain coefficient and scale current results with it
// - hold a separate 16-bit voltage gain coefficient scaling voltage results
// - load both coefficients from factory value inputs at power-on
// - a current gain calibration replaces the current coefficient with its outcome
// - a voltage gain calibration overwrites the voltage coefficient with its outcome
//
// Local design decision: the APB register port.
`timescale 1ns/100ps
`default_nettype none
module agcr_top
   import agcr_pkg::*;
#(
   parameter int unsigned RES_W = 16,
   parameter int unsigned IDLE_CYC = AGCR_IDLE_MIN_CYC
) (
   input wire logic core_clk_in,
   input wire logic rst_in,
   // apb slave
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [AGCR_ADDR_W-1:0] paddr_in,
   input wire logic [AGCR_DATA_W-1:0] pwdata_in,
   output logic [AGCR_DATA_W-1:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // factory trim values
   input wire logic [AGCR_GAIN_W-1:0] factory_cur_gain_in,
   input wire logic [AGCR_GAIN_W-1:0] factory_vol_gain_in,
   // converter core
   output logic conv_enable_out,
   output logic [AGCR_CTRL_MODE_W-1:0] conv_mode_out,
   output logic cal_start_out,
   input wire logic cal_done_in,
   input wire logic [AGCR_GAIN_W-1:0] cal_gain_in,
   // raw and scaled results
   input wire logic [RES_W-1:0] cur_raw_in,
   input wire logic cur_raw_valid_in,
   input wire logic [RES_W-1:0] vol_raw_in,
   input wire logic vol_raw_valid_in,
   output logic [RES_W-1:0] cur_result_out,
   output logic cur_result_valid_out,
   output logic [RES_W-1:0] vol_result_out,
   output logic vol_result_valid_out
);
   typedef enum logic [2:0] {
      AGCR_SEL_NONE,
      AGCR_SEL_CUR,
      AGCR_SEL_VOL,
      AGCR_SEL_CTRL,
      AGCR_SEL_STATUS
   } agcr_sel_t;

   function automatic agcr_sel_t agcr_decode(input logic [AGCR_ADDR_W-1:0] addr);
      agcr_sel_t sel;
      sel = AGCR_SEL_NONE;
      if (addr == AGCR_CUR_GAIN_ADDR) begin
         sel = AGCR_SEL_CUR;
      end else if (addr == AGCR_VOL_GAIN_ADDR) begin
         sel = AGCR_SEL_VOL;
      end else if (addr == AGCR_CTRL_ADDR) begin
         sel = AGCR_SEL_CTRL;
      end else if (addr == AGCR_STATUS_ADDR) begin
         sel = AGCR_SEL_STATUS;
      end
      return sel;
   endfunction : agcr_decode

   // register state
   logic [AGCR_GAIN_W-1:0] cur_gain_d;
   logic [AGCR_GAIN_W-1:0] cur_gain_q;
   logic [AGCR_GAIN_W-1:0] vol_gain_d;
   logic [AGCR_GAIN_W-1:0] vol_gain_q;
   logic en_d;
   logic en_q;
   logic [AGCR_CTRL_MODE_W-1:0] mode_d;
   logic [AGCR_CTRL_MODE_W-1:0] mode_q;
   logic busy_d;
   logic busy_q;
   logic refused_d;
   logic refused_q;
   logic start_d;
   logic start_q;
   logic [AGCR_DATA_W-1:0] rdata_d;
   logic [AGCR_DATA_W-1:0] rdata_q;
   logic err_d;
   logic err_q;

   agcr_sel_t sel;
   logic setup;
   logic wr_fire;
   logic write_open;
   logic [AGCR_DATA_W-1:0] status_word;
   logic [AGCR_DATA_W-1:0] ctrl_word;
   logic [AGCR_CTRL_MODE_W-1:0] wr_mode;

   agcr_idle_timer #(
      .MIN_CYC(IDLE_CYC)
   ) u_idle_timer (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .enabled_in(en_q),
      .idle_in(mode_q == AGCR_MODE_IDLE && !busy_q),
      .open_out(write_open)
   );

   assign sel = agcr_decode(paddr_in);
   assign setup = psel_in && !penable_in;
   // zero-wait slave: every access phase completes at once
   assign wr_fire = psel_in && penable_in && pwrite_in;
   assign wr_mode = pwdata_in[AGCR_CTRL_MODE_LSB +: AGCR_CTRL_MODE_W];

   always_comb begin
      status_word = '0;
      status_word[AGCR_STAT_OPEN_BIT] = write_open;
      status_word[AGCR_STAT_BUSY_BIT] = busy_q;
      status_word[AGCR_STAT_REFUSED_BIT] = refused_q;
      ctrl_word = '0;
      ctrl_word[AGCR_CTRL_EN_BIT] = en_q;
      ctrl_word[AGCR_CTRL_MODE_LSB +: AGCR_CTRL_MODE_W] = mode_q;
   end

   // read data and error latched at setup, shown during the access phase
   always_comb begin
      rdata_d = rdata_q;
      err_d = err_q;
      if (rst_in) begin
         rdata_d = '0;
         err_d = 1'b0;
      end else if (setup) begin
         err_d = (sel == AGCR_SEL_NONE);
         rdata_d = '0;
         if (!pwrite_in) begin
            if (sel == AGCR_SEL_CUR) begin
               rdata_d = AGCR_DATA_W'(cur_gain_q);
            end else if (sel == AGCR_SEL_VOL) begin
               rdata_d = AGCR_DATA_W'(vol_gain_q);
            end else if (sel == AGCR_SEL_CTRL) begin
               rdata_d = ctrl_word;
            end else if (sel == AGCR_SEL_STATUS) begin
               rdata_d = status_word;
            end
         end
      end
   end

   // coefficient registers
   always_comb begin
      cur_gain_d = cur_gain_q;
      vol_gain_d = vol_gain_q;
      if (rst_in) begin
         cur_gain_d = factory_cur_gain_in;
         vol_gain_d = factory_vol_gain_in;
      end else begin
         // a guarded write ahead of the idle interval changes no coefficient, only the refused flag
         if (wr_fire && write_open) begin
            if (sel == AGCR_SEL_CUR) begin
               cur_gain_d = pwdata_in[AGCR_GAIN_W-1:0];
            end else if (sel == AGCR_SEL_VOL) begin
               vol_gain_d = pwdata_in[AGCR_GAIN_W-1:0];
            end
         end
         // calibration outcome lands last so it wins over a same-cycle write
         if (busy_q && cal_done_in) begin
            if (mode_q == AGCR_MODE_CAL_CUR) begin
               cur_gain_d = cal_gain_in;
            end else if (mode_q == AGCR_MODE_CAL_VOL) begin
               vol_gain_d = cal_gain_in;
            end
         end
      end
   end

   // converter mode, calibration sequencing, status flags
   always_comb begin
      en_d = en_q;
      mode_d = mode_q;
      busy_d = busy_q;
      refused_d = refused_q;
      start_d = 1'b0;
      if (rst_in) begin
         en_d = AGCR_CTRL_RESET[AGCR_CTRL_EN_BIT];
         mode_d = AGCR_CTRL_RESET[AGCR_CTRL_MODE_LSB +: AGCR_CTRL_MODE_W];
         busy_d = 1'b0;
         refused_d = 1'b0;
      end else begin
         if (wr_fire && sel == AGCR_SEL_CTRL) begin
            en_d = pwdata_in[AGCR_CTRL_EN_BIT];
            mode_d = wr_mode;
            busy_d = 1'b0;
            // calibration only runs on an enabled converter
            if (pwdata_in[AGCR_CTRL_EN_BIT] &&
                (wr_mode == AGCR_MODE_CAL_CUR || wr_mode == AGCR_MODE_CAL_VOL)) begin
               start_d = 1'b1;
               busy_d = 1'b1;
            end
         end else if (busy_q && cal_done_in) begin
            busy_d = 1'b0;
            mode_d = AGCR_MODE_IDLE;
         end
         // write one to clear; a new refusal in the same cycle keeps it set
         if (wr_fire && sel == AGCR_SEL_STATUS && pwdata_in[AGCR_STAT_REFUSED_BIT]) begin
            refused_d = 1'b0;
         end
         if (wr_fire && !write_open && (sel == AGCR_SEL_CUR || sel == AGCR_SEL_VOL)) begin
            refused_d = 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk_in) begin
      cur_gain_q <= cur_gain_d;
      vol_gain_q <= vol_gain_d;
      en_q <= en_d;
      mode_q <= mode_d;
      busy_q <= busy_d;
      refused_q <= refused_d;
      start_q <= start_d;
      rdata_q <= rdata_d;
      err_q <= err_d;
   end

   agcr_scaler #(
      .RES_W(RES_W)
   ) u_cur_scaler (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .raw_in(cur_raw_in),
      .raw_valid_in(cur_raw_valid_in),
      .gain_in(cur_gain_q),
      .scaled_out(cur_result_out),
      .scaled_valid_out(cur_result_valid_out)
   );

   agcr_scaler #(
      .RES_W(RES_W)
   ) u_vol_scaler (
      .core_clk_in(core_clk_in),
      .rst_in(rst_in),
      .raw_in(vol_raw_in),
      .raw_valid_in(vol_raw_valid_in),
      .gain_in(vol_gain_q),
      .scaled_out(vol_result_out),
      .scaled_valid_out(vol_result_valid_out)
   );

   assign prdata_out = rdata_q;
   assign pready_out = psel_in && penable_in;
   assign pslverr_out = psel_in && penable_in && err_q;
   assign conv_enable_out = en_q;
   assign conv_mode_out = mode_q;
   assign cal_start_out = start_q;
endmodule : agcr_top
`default_nettype wire

// ===== agcr_top_bench.sv
// bench for agcr_top: apb register calls, result pulses, calibration answers
// assumes the idle window shortened to 8 cycles
`timescale 1ns/100ps
`default_nettype none
module agcr_top_bench import agcr_pkg::*;;
   localparam int unsigned IDLE = 8;
   logic clk = 1'b0;
   logic rst, psel, pen, pwr, pready, er, re, cal_done, cur_rv, vol_rv, cal_start;
   logic [31:0] addr, wdata, prdata, rd;
   logic [15:0] cal_gain, cur_raw, vol_raw, cur_res, vol_res;
   int err_total = 0;
   int samples_checked = 0;
   always #10 clk = ~clk;
   agcr_top #(.RES_W(16), .IDLE_CYC(IDLE)) agcr_top_inst (.core_clk_in(clk), .rst_in(rst),
      .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(addr), .pwdata_in(wdata),
      .prdata_out(prdata), .pready_out(pready), .pslverr_out(er),
      .factory_cur_gain_in(16'h8000), .factory_vol_gain_in(16'h4000),
      .conv_enable_out(), .conv_mode_out(), .cal_start_out(cal_start),
      .cal_done_in(cal_done), .cal_gain_in(cal_gain), .cur_raw_in(cur_raw),
      .cur_raw_valid_in(cur_rv), .vol_raw_in(vol_raw), .vol_raw_valid_in(vol_rv),
      .cur_result_out(cur_res), .cur_result_valid_out(), .vol_result_out(vol_res),
      .vol_result_valid_out());
   task results();
      if (err_total == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results
   task check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task bail(input int n);
      if (n > 20) begin
         err_total++;
         results();
      end
   endtask : bail
   // setup then access; holds everything until ready is sampled
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         bail(++n);
      end while (pready !== 1'b1);
      rd = prdata;
      re = er;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask : apb
   task rdc(input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check(rd, e);
   endtask : rdc
   task scale(input logic [15:0] c, input logic [15:0] v, input logic [15:0] ec,
      input logic [15:0] ev);
      @(posedge clk);
      cur_raw <= c;
      vol_raw <= v;
      cur_rv <= 1'b1;
      vol_rv <= 1'b1;
      @(posedge clk);
      cur_rv <= 1'b0;
      vol_rv <= 1'b0;
      #1;
      check({16'h0, cur_res}, {16'h0, ec});
      check({16'h0, vol_res}, {16'h0, ev});
   endtask : scale
   // converter core answers one start with one done pulse
   task cal(input logic [31:0] c, input logic [15:0] g);
      int n;
      apb(1'b1, AGCR_CTRL_ADDR, c);
      n = 0;
      while (cal_start !== 1'b1) begin
         @(posedge clk);
         bail(++n);
      end
      cal_done <= 1'b1;
      cal_gain <= g;
      @(posedge clk);
      cal_done <= 1'b0;
   endtask : cal
   initial begin
      #1000000;
      err_total++;
      results();
   end
   initial begin
      {rst, psel, pen, pwr, cal_done, cur_rv, vol_rv} <= 7'h40;
      {addr, wdata} <= 64'h0;
      {cal_gain, cur_raw, vol_raw} <= 48'h0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      rdc(AGCR_CUR_GAIN_ADDR, 32'h8000);
      rdc(AGCR_VOL_GAIN_ADDR, 32'h4000);
      scale(16'h1234, 16'h1000, 16'h1234, 16'h0800);
      scale(16'h0, 16'h0, 16'h0, 16'h0);
      apb(1'b1, AGCR_CUR_GAIN_ADDR, 32'h1111);
      rdc(AGCR_CUR_GAIN_ADDR, 32'h8000);
      rdc(AGCR_STATUS_ADDR, 32'h4);
      apb(1'b1, AGCR_STATUS_ADDR, 32'h4);
      apb(1'b1, AGCR_CTRL_ADDR, 32'h1);
      repeat (IDLE + 4) @(posedge clk);
      rdc(AGCR_STATUS_ADDR, 32'h1);
      apb(1'b1, AGCR_CUR_GAIN_ADDR, 32'hffff2222);
      apb(1'b1, AGCR_VOL_GAIN_ADDR, 32'hc000);
      rdc(AGCR_CUR_GAIN_ADDR, 32'h2222);
      rdc(AGCR_VOL_GAIN_ADDR, 32'hc000);
      // window restarts after a break, so a quick write is dropped
      apb(1'b1, AGCR_CTRL_ADDR, 32'h0);
      apb(1'b1, AGCR_CTRL_ADDR, 32'h1);
      apb(1'b1, AGCR_VOL_GAIN_ADDR, 32'h5555);
      rdc(AGCR_VOL_GAIN_ADDR, 32'hc000);
      scale(16'h1000, 16'hffff, 16'h0444, 16'hffff);
      cal(32'h5, 16'habcd);
      rdc(AGCR_CUR_GAIN_ADDR, 32'habcd);
      rdc(AGCR_CTRL_ADDR, 32'h1);
      cal(32'h7, 16'h1357);
      rdc(AGCR_VOL_GAIN_ADDR, 32'h1357);
      apb(1'b1, AGCR_CTRL_ADDR, 32'h4);
      rdc(AGCR_STATUS_ADDR, 32'h4);
      rdc(AGCR_CUR_GAIN_ADDR, 32'habcd);
      apb(1'b0, 32'hffff0544, 32'h0);
      check({31'h0, re}, 32'h1);
      results();
   end
endmodule : agcr_top_bench
bind agcr_top agcr_props #(.RES_W(RES_W)) agcr_props_inst (.core_clk_in(core_clk_in),
   .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
   .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
   .conv_enable_out(conv_enable_out), .conv_mode_out(conv_mode_out),
   .cal_start_out(cal_start_out), .cal_done_in(cal_done_in), .cur_raw_in(cur_raw_in),
   .cur_raw_valid_in(cur_raw_valid_in), .vol_raw_valid_in(vol_raw_valid_in),
   .cur_result_out(cur_result_out), .cur_result_valid_out(cur_result_valid_out),
   .vol_result_valid_out(vol_result_valid_out));
`default_nettype wire
